/* hdl/stb_consts.svh */
// Offsets, field positions, reset values and counts of the serial tx block
// Included by the package and the design files
`ifndef STB_CONSTS_SVH
`define STB_CONSTS_SVH
`define STB_ADDR_W          3
`define STB_OFS_HOLD        3'h0
`define STB_OFS_FMT         3'h1
`define STB_OFS_CTL         3'h2
`define STB_OFS_FLAGS       3'h3
`define STB_OFS_DIV         3'h4
`define STB_HOLD_RST        8'hFF
`define STB_FMT_RST         8'h00
`define STB_CTL_RST         8'h00
`define STB_DIV_RST         8'h00
`define STB_FMT_SYNC        7
`define STB_FMT_CHR         6
`define STB_FMT_PE          5
`define STB_FMT_PM          4
`define STB_FMT_STOP        3
`define STB_FMT_MP          2
`define STB_CTL_TE          5
`define STB_CTL_FIVE        0
`define STB_FLG_EMPTY       7
`define STB_FLG_END         2
`define STB_FLG_MPBT        0
`define STB_SRC_SYS         2'h0
`define STB_SRC_SUB         2'h1
`define STB_SRC_DIV16       2'h2
`define STB_SRC_DIV64       2'h3
`define STB_PRE_W           6
`define STB_PRE_16          6'h0F
`define STB_PRE_64          6'h3F
`define STB_FRAME_W         12
`define STB_LEN_W           4
`endif

/* hdl/stb_pkg.sv */
// Types of the serial tx block
// Relies on stb_consts.svh for widths
`include "stb_consts.svh"
package stb_pkg;
  typedef logic [`STB_ADDR_W-1:0]  stb_addr_t;
  typedef logic [7:0]              stb_byte_t;
  typedef logic [`STB_FRAME_W-1:0] stb_frame_t;
  typedef logic [`STB_LEN_W-1:0]   stb_len_t;
  typedef enum logic {STB_IDLE, STB_SHIFT} stb_state_t;
endpackage : stb_pkg

/* hdl/stb_tx_if.sv */
// Link between the register side and the tx shifter
// Both ends run on the same clock
`timescale 1ns/1ps
interface stb_tx_if;
  import stb_pkg::*;
  logic       srcTick;
  stb_byte_t  divisor;
  logic       loadValid;
  logic       loadReady;
  stb_frame_t frameBits;
  stb_len_t   frameLen;
  logic       busy;
  logic       serialOut;
  modport ctrl (output srcTick, divisor, loadValid, frameBits, frameLen,
                input loadReady, busy, serialOut);
  modport shifter (input srcTick, divisor, loadValid, frameBits, frameLen,
                   output loadReady, busy, serialOut);
endinterface : stb_tx_if

/* hdl/stb_tx_shifter.sv */
// Hidden tx shift register: sends a prebuilt frame LSB first
// Assumes one srcTick pulse per prescaled clock, divisor+1 ticks a bit
`timescale 1ns/1ps
`include "stb_consts.svh"
module stb_tx_shifter
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link to the register side
  stb_tx_if.shifter tx
);
  import stb_pkg::*;

  stb_state_t state_reg;
  stb_frame_t shift_reg;
  stb_len_t   left_reg;
  stb_byte_t  tick_reg;
  logic       bitEnd;
  logic       take;

  assign bitEnd       = (state_reg == STB_SHIFT) && tx.srcTick
                        && (tick_reg == tx.divisor);
  // Ready one cycle early on the last bit so frames follow gapless
  assign tx.loadReady = (state_reg == STB_IDLE)
                        || (bitEnd && (left_reg == `STB_LEN_W'(1)));
  assign take         = tx.loadValid && tx.loadReady;
  assign tx.busy      = (state_reg == STB_SHIFT);
  assign tx.serialOut = (state_reg == STB_SHIFT) ? shift_reg[0] : 1'b1;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_reg <= STB_IDLE;
    else if (take)
      state_reg <= STB_SHIFT;
    else
    begin
      case (state_reg)
        STB_IDLE:
          state_reg <= STB_IDLE;
        STB_SHIFT:
          if (bitEnd && (left_reg == `STB_LEN_W'(1)))
            state_reg <= STB_IDLE;
        default:
          state_reg <= STB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      shift_reg <= '1;
      left_reg  <= '0;
    end
    else if (take)
    begin
      shift_reg <= tx.frameBits;
      left_reg  <= tx.frameLen;
    end
    else if (bitEnd)
    begin
      shift_reg <= {1'b1, shift_reg[`STB_FRAME_W-1:1]}; // [R1]
      left_reg  <= left_reg - `STB_LEN_W'(1);
    end
  end

  // Bit timer restarts with each frame
  always_ff @(posedge clk)
  begin
    if (!rst_n || take)
      tick_reg <= '0;
    else if (tx.srcTick && (state_reg == STB_SHIFT))
      tick_reg <= (tick_reg == tx.divisor) ? 8'h00 : tick_reg + 8'h01;
  end
endmodule : stb_tx_shifter

/* hdl/stb_tx_top.sv */
// Serial transmit buffer, frame format and baud source selection
// Assumes a register port master and synchronous subclock tick input
//
// Summary of operation
// R1: Frame bits leave the shifter LSB first
// R2: No transfer while the empty flag is set
// R3: Shift register has no software address
// R4: Holding byte moves to shifter when empty
// R5: Pending byte follows the current frame gaplessly
// R6: Software writes once after seeing empty flag
// R7: Holding register resets and standby to FF
// R8: Format register resets and standby to zero
// R9: Parity sense even/odd, async with parity
// R10: Parity bit makes data ones even/odd
// R11: Parity sense ignored when parity disabled
// R12: Stop bit count one or two, async
// R13: Receiver checks first stop bit only
// R14: Multiprocessor mode overrides parity settings
// R15: Software keeps multiprocessor off in sync
// R16: Baud source: sub/2, sys/16, sys/64
// R17: Subclock source needs CPU on subclock
// R18: Async length 7, 8 or 5; sync 8
// R19: Empty flag held at one without enable
// R20: Holding write with enable clears empty flag
// R21: Unused high bits of short characters dropped
// R22: Source code 00 selects the system clock
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "stb_consts.svh"
module stb_tx_top
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port
  input  wire stb_pkg::stb_addr_t regAddr,
  input  wire stb_pkg::stb_byte_t regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output stb_pkg::stb_byte_t     regRdata,
  // Power states
  input  wire logic              lowPowerInit,
  input  wire logic              subMode,
  input  wire logic              cpuOnSubclock,
  input  wire logic              subClkTick,
  // Serial line
  output logic                   serialOutPin
);
  import stb_pkg::*;

  stb_tx_if tx ();

  stb_byte_t transmitHolding_reg;
  stb_byte_t serialFormatConfig_reg;
  stb_byte_t ctl_reg;
  stb_byte_t div_reg;
  logic      txEmptyFlag_reg;
  logic      mpbt_reg;
  logic      subHalf_reg;
  logic      [`STB_PRE_W-1:0] pre_reg;
  stb_byte_t rdata_reg;
  logic      serialOut_reg;

  logic      initNow;
  logic      txEnable;
  logic      holdWrite;
  logic      runAllowed;
  logic      transfer;
  logic      [1:0] baudSrc;

  // Frame assembly: start, data, optional parity or mp bit, stops; sync frames are data only
  function automatic stb_frame_t build_frame(input stb_byte_t data,
                                             input stb_byte_t fmt,
                                             input logic five,
                                             input logic mpb);
    stb_frame_t f;
    int         dlen;
    int         pos;
    logic       par;
    f    = '1;
    dlen = fmt[`STB_FMT_SYNC] ? 8 : five ? 5 : fmt[`STB_FMT_CHR] ? 7 : 8;
    par  = fmt[`STB_FMT_PM];                                   // [R9]
    if (fmt[`STB_FMT_SYNC])
      f[7:0] = data;
    else
    begin
      f[0] = 1'b0;
      for (int i = 0; i < 8; i++)
        if (i < dlen)                                          // [R21]
        begin
          f[1+i] = data[i];
          par    = par ^ data[i];                              // [R10]
        end
      pos = 1 + dlen;
      if (fmt[`STB_FMT_MP])                                    // [R14]
        f[pos] = mpb;
      else if (fmt[`STB_FMT_PE])                               // [R11]
        f[pos] = par;
    end
    return f;
  endfunction : build_frame

  function automatic stb_len_t frame_len(input stb_byte_t fmt,
                                         input logic five);
    int n;
    n = fmt[`STB_FMT_CHR] ? 7 : 8;
    if (five)
      n = 5;
    n = 1 + n + 1;
    if (fmt[`STB_FMT_MP] || fmt[`STB_FMT_PE])
      n = n + 1;
    if (fmt[`STB_FMT_STOP])                                    // [R12]
      n = n + 1;
    if (fmt[`STB_FMT_SYNC])                                    // [R18]
      n = 8;
    return stb_len_t'(n);
  endfunction : frame_len

  assign initNow    = !rst_n || lowPowerInit;
  assign txEnable   = ctl_reg[`STB_CTL_TE];
  assign holdWrite  = regWrite && (regAddr == `STB_OFS_HOLD);
  assign baudSrc    = serialFormatConfig_reg[1:0];
  assign runAllowed = !(subMode && (baudSrc == `STB_SRC_SUB)
                        && !cpuOnSubclock);                    // [R17]
  assign transfer   = tx.loadValid && tx.loadReady;

  // Shifter is fed only from the holding register [R3]
  assign tx.loadValid = txEnable && !txEmptyFlag_reg && runAllowed; // [R2]
  assign tx.frameBits = build_frame(transmitHolding_reg,
                                    serialFormatConfig_reg,
                                    ctl_reg[`STB_CTL_FIVE], mpbt_reg);
  assign tx.frameLen  = frame_len(serialFormatConfig_reg,
                                  ctl_reg[`STB_CTL_FIVE]);
  assign tx.divisor   = div_reg;

  stb_tx_shifter u_shifter
  (
    .clk   (clk),
    .rst_n (rst_n && !lowPowerInit),
    .tx    (tx.shifter)
  );

  always_ff @(posedge clk)
  begin
    if (initNow)
      transmitHolding_reg <= `STB_HOLD_RST;                    // [R7]
    else if (holdWrite)
      transmitHolding_reg <= regWdata;
  end

  always_ff @(posedge clk)
  begin
    if (initNow)
      serialFormatConfig_reg <= `STB_FMT_RST;                  // [R8]
    else if (regWrite && (regAddr == `STB_OFS_FMT))
      serialFormatConfig_reg <= regWdata;
  end

  always_ff @(posedge clk)
  begin
    if (initNow)
    begin
      ctl_reg  <= `STB_CTL_RST;
      div_reg  <= `STB_DIV_RST;
      mpbt_reg <= 1'b0;
    end
    else if (regWrite)
    begin
      if (regAddr == `STB_OFS_CTL)
        ctl_reg <= regWdata;
      if (regAddr == `STB_OFS_DIV)
        div_reg <= regWdata;
      if (regAddr == `STB_OFS_FLAGS)
        mpbt_reg <= regWdata[`STB_FLG_MPBT];
    end
  end

  // Empty flag: transfer sets it and wins over a same-cycle write
  always_ff @(posedge clk)
  begin
    if (initNow || !txEnable)
      txEmptyFlag_reg <= 1'b1;                                 // [R19]
    else if (transfer)
      txEmptyFlag_reg <= 1'b1;                                 // [R4] [R5]
    else if (holdWrite)
      txEmptyFlag_reg <= 1'b0;                                 // [R20]
  end

  // Baud source prescaler
  always_ff @(posedge clk)
  begin
    if (initNow)
    begin
      pre_reg     <= '0;
      subHalf_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_reg + `STB_PRE_W'(1);
      if (subClkTick)
        subHalf_reg <= !subHalf_reg;
    end
  end

  always_comb
  begin
    case (baudSrc)                                             // [R16]
      `STB_SRC_SYS:
        tx.srcTick = runAllowed;                               // [R22]
      `STB_SRC_SUB:
        tx.srcTick = runAllowed && subClkTick && subHalf_reg;
      `STB_SRC_DIV16:
        tx.srcTick = runAllowed && (pre_reg[3:0] == 4'(`STB_PRE_16));
      `STB_SRC_DIV64:
        tx.srcTick = runAllowed && (pre_reg == `STB_PRE_64);
      default:
        tx.srcTick = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        `STB_OFS_HOLD:  rdata_reg <= transmitHolding_reg;
        `STB_OFS_FMT:   rdata_reg <= serialFormatConfig_reg;
        `STB_OFS_CTL:   rdata_reg <= ctl_reg;
        `STB_OFS_DIV:   rdata_reg <= div_reg;
        `STB_OFS_FLAGS:
          rdata_reg <= {txEmptyFlag_reg, 4'h0,
                        txEmptyFlag_reg && !tx.busy, 1'b0, mpbt_reg};
        default:        rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      serialOut_reg <= 1'b1;
    else
      serialOut_reg <= tx.serialOut;
  end

  assign regRdata     = rdata_reg;
  assign serialOutPin = serialOut_reg;
endmodule : stb_tx_top

/* testbench/stb_rx_model.sv */
// Far receiver on the serial line: captures one burst of bits
// Bench sets bit length and count before the start edge
`timescale 1ns/1ps
module stb_rx_model
(
  // Clock
  input  wire logic        clk,
  // Line and frame shape
  input  wire logic        serialIn,
  input  wire logic [15:0] bitClocks,
  input  wire logic [4:0]  bitCount,
  // Captured burst
  output logic [23:0]      rxBits,
  output int               rxCount
);
  initial
  begin
    rxBits = '0;
    rxCount = 0;
    forever
    begin
      @(negedge clk);
      if (serialIn === 1'b0)
      begin
        rxBits = '0;
        repeat (bitClocks / 2) @(negedge clk);
        // Mid-bit samples, first bit on bit 0; stop not judged
        for (int i = 0; i < bitCount; i++)
        begin
          rxBits[i] = serialIn;
          if (i + 1 < bitCount)
            repeat (bitClocks) @(negedge clk);
        end
        rxCount++;
      end
    end
  end
endmodule : stb_rx_model

/* testbench/stb_tx_chk.sv */
// Assertions on the register port and line of the serial tx block
// Bound into stb_tx_top; sees only its ports
`timescale 1ns/1ps
`include "stb_consts.svh"
module stb_tx_chk
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // Watched ports
  input wire stb_pkg::stb_addr_t regAddr,
  input wire stb_pkg::stb_byte_t regWdata,
  input wire logic               regWrite,
  input wire logic               regRead,
  input wire stb_pkg::stb_byte_t regRdata,
  input wire logic               lowPowerInit,
  input wire logic               subMode,
  input wire logic               cpuOnSubclock,
  input wire logic               serialOutPin
);
  import stb_pkg::*;
  logic      teReg;
  stb_byte_t fmtReg;
  logic      gated;
  logic      clr;
  assign clr = !rst_n || lowPowerInit;
  assign gated = subMode && !cpuOnSubclock && !lowPowerInit
                 && fmtReg[1:0] == `STB_SRC_SUB;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk)
    if (clr)
      teReg <= 1'b0;
    else if (regWrite && regAddr == `STB_OFS_CTL)
      teReg <= regWdata[`STB_CTL_TE];
  always_ff @(posedge clk)
    if (clr)
      fmtReg <= 8'h00;
    else if (regWrite && regAddr == `STB_OFS_FMT)
      fmtReg <= regWdata;
  sequence s_hold_wr;
    regWrite && regAddr == `STB_OFS_HOLD && teReg && !lowPowerInit;
  endsequence
  sequence s_rd(stb_addr_t a);
    regRead && regAddr == a && !lowPowerInit;
  endsequence
  a_rdata_idle:
    assert property (!regRead |=> regRdata == 8'h00)
      else $error("read data outside slot");
  a_gap_read:
    assert property (regRead && regAddr > `STB_OFS_DIV |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
  a_hold_init:
    assert property (lowPowerInit ##1 s_rd(`STB_OFS_HOLD)
      |=> regRdata == `STB_HOLD_RST) else $error("hold not forced");
  a_fmt_init:
    assert property (lowPowerInit ##1 s_rd(`STB_OFS_FMT)
      |=> regRdata == `STB_FMT_RST) else $error("format not cleared");
  a_fmt_back:
    assert property ((regWrite && regAddr == `STB_OFS_FMT && !lowPowerInit)
      ##1 s_rd(`STB_OFS_FMT) |=> regRdata == $past(regWdata, 2))
      else $error("format readback wrong");
  a_empty_held:
    assert property (regRead && regAddr == `STB_OFS_FLAGS && !teReg
      |=> regRdata[`STB_FLG_EMPTY]) else $error("empty flag not held");
  a_write_clears:
    assert property (s_hold_wr ##1 s_rd(`STB_OFS_FLAGS)
      |=> !regRdata[`STB_FLG_EMPTY]) else $error("empty flag not cleared");
  a_sub_gate:
    assert property (gated [*3] |-> $stable(serialOutPin))
      else $error("line moved while gated");
endmodule : stb_tx_chk
bind stb_tx_top stb_tx_chk chk (.clk(clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .lowPowerInit(lowPowerInit),
  .subMode(subMode), .cpuOnSubclock(cpuOnSubclock),
  .serialOutPin(serialOutPin));

/* testbench/stb_tx_top_tb.sv */
// Self-checking bench of the serial tx block
// Drives the register port; the line is read by stb_rx_model
`timescale 1ns/1ps
`include "stb_consts.svh"
module stb_tx_top_tb;
  import stb_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  stb_addr_t   regAddr = '0;
  stb_byte_t   regWdata = '0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  stb_byte_t   regRdata;
  logic        lowPowerInit = 1'b0;
  logic        subMode = 1'b0;
  logic        cpuOnSubclock = 1'b0;
  logic        subClkTick = 1'b0;
  logic        serialOutPin;
  logic [15:0] bitClocks = 16'h0004;
  logic [4:0]  bitCount = 5'h0A;
  logic [23:0] rxBits;
  int          rxCount;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  stb_byte_t   rnd = 8'h25;
  stb_tx_top DUT (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .lowPowerInit(lowPowerInit), .subMode(subMode),
    .cpuOnSubclock(cpuOnSubclock), .subClkTick(subClkTick),
    .serialOutPin(serialOutPin));
  stb_rx_model rxModel (.clk(clk), .serialIn(serialOutPin),
    .bitClocks(bitClocks), .bitCount(bitCount), .rxBits(rxBits),
    .rxCount(rxCount));
  always #20 clk = ~clk;
  always @(posedge clk) subClkTick <= ~subClkTick;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_fail++;
      results();
    end
  end
  function automatic stb_byte_t nxt(input stb_byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  // Line bits from bit 0 on: start, data, parity or mp, stops
  function automatic logic [23:0] frame(input stb_byte_t d,
    input stb_byte_t f, input logic five, output int n);
    int w;
    logic [23:0] b;
    w = five ? 5 : (f[`STB_FMT_CHR] ? 7 : 8);
    b = '0;
    for (int i = 0; i < w; i++)
      b[1 + i] = d[i];
    n = w + 1;
    if (f[`STB_FMT_MP])
      n++;
    else if (f[`STB_FMT_PE])
    begin
      b[n] = ^(d & ~(8'hFF << w)) ^ f[`STB_FMT_PM];
      n++;
    end
    b[n] = 1'b1;
    b[n + 1] = f[`STB_FMT_STOP];
    n = n + 1 + f[`STB_FMT_STOP];
    return b;
  endfunction : frame
  task automatic cyc(input logic w, input logic r, input stb_addr_t a,
    input stb_byte_t d);
    regWrite <= w;
    regRead <= r;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
  endtask : cyc
  task automatic wr(input stb_addr_t a, input stb_byte_t d);
    cyc(1'b1, 1'b0, a, d);
    cyc(1'b0, 1'b0, a, d);
  endtask : wr
  task automatic rd(input stb_addr_t a, output stb_byte_t d);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, a, 8'h00);
    d = regRdata;
  endtask : rd
  task automatic chk8(input stb_byte_t g, input stb_byte_t e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk24(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk24
  task automatic waitrx(input int c);
    for (int k = 0; k < 8000 && rxCount == c; k++)
      @(posedge clk);
  endtask : waitrx
  // Two bytes, the second written while the first is on the line
  task automatic send(input stb_byte_t f, input logic five);
    stb_byte_t d1, d2, g;
    logic [23:0] e;
    int n1, n2, c;
    rnd = nxt(rnd);
    d1 = rnd;
    rnd = nxt(rnd);
    d2 = rnd;
    e = frame(d2, f, five, n2);
    e = frame(d1, f, five, n1) | (e << n1);
    bitCount <= 5'(n1 + n2);
    bitClocks <= 16'h0004 << (2 * f[1:0]);
    c = rxCount;
    cyc(1'b1, 1'b0, `STB_OFS_FMT, f);
    cyc(1'b0, 1'b1, `STB_OFS_FMT, 8'h00);
    cyc(1'b0, 1'b0, `STB_OFS_FMT, 8'h00);
    chk8(regRdata, f);
    wr(`STB_OFS_CTL, 8'h20 | {7'h00, five});
    rd(`STB_OFS_FLAGS, g);
    chk8(g & 8'h80, 8'h80);
    cyc(1'b1, 1'b0, `STB_OFS_HOLD, d1);
    cyc(1'b0, 1'b1, `STB_OFS_FLAGS, 8'h00);
    cyc(1'b0, 1'b0, `STB_OFS_FLAGS, 8'h00);
    g = regRdata;
    chk8(g & 8'h80, 8'h00);
    for (int k = 0; k < 20 && g[7] !== 1'b1; k++)
      rd(`STB_OFS_FLAGS, g);
    wr(`STB_OFS_HOLD, d2);
    waitrx(c);
    chk24(rxBits, e);
    repeat (bitClocks) @(posedge clk);
  endtask : send
  task automatic results();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    stb_byte_t g;
    int n;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 2; a++)
    begin
      rd(3'(a), g);
      chk8(g, a ? 8'h00 : 8'hFF);
    end
    wr(`STB_OFS_HOLD, 8'h3C);
    wr(`STB_OFS_FMT, 8'h5A);
    wr(3'h5, 8'hA5);
    rd(3'h5, g);
    chk8(g, 8'h00);
    rd(`STB_OFS_FLAGS, g);
    chk8(g & 8'h80, 8'h80);
    chk8({7'h00, serialOutPin}, 8'h01);
    for (int a = 0; a < 2; a++)
    begin
      lowPowerInit <= 1'b1;
      @(posedge clk);
      lowPowerInit <= 1'b0;
      rd(3'(a), g);
      chk8(g, a ? 8'h00 : 8'hFF);
    end
    wr(`STB_OFS_DIV, 8'h03);
    send(8'h3C, 1'b1);
    send(8'h70, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      rnd = nxt(rnd);
      send({1'b0, rnd[6:2], 2'(k)}, rnd[7] & ~rnd[6]);
    end
    // Clock synchronous frame: 8 bits, no start or stop, mp kept off
    wr(`STB_OFS_FMT, 8'h80);
    bitClocks <= 16'h0004;
    bitCount <= 5'h08;
    n = rxCount;
    wr(`STB_OFS_HOLD, 8'hA6);
    waitrx(n);
    chk24(rxBits, 24'h0000A6);
    repeat (8) @(posedge clk);
    subMode <= 1'b1;
    wr(`STB_OFS_FMT, 8'h01);
    wr(`STB_OFS_CTL, 8'h20);
    bitClocks <= 16'h0010;
    bitCount <= 5'h0A;
    n = rxCount;
    wr(`STB_OFS_HOLD, 8'hA6);
    repeat (100) @(posedge clk);
    chk8({7'h00, serialOutPin}, 8'h01);
    chk8(8'(rxCount - n), 8'h00);
    rd(`STB_OFS_FLAGS, g);
    chk8(g & 8'h80, 8'h00);
    cpuOnSubclock <= 1'b1;
    waitrx(n);
    chk24(rxBits, frame(8'hA6, 8'h01, 1'b0, n));
    results();
  end
endmodule : stb_tx_top_tb
